// *** sss_defines.svh ***
// Constants for the sensor scan sequencer: offsets, fields, timing counts.
// Assumes a 20 MHz system clock; included by the package and the top.
// Functional notes
// R01 - Select channel, route muxes, excite, settle
// R02 - Start conversion after settle, scan continues
// R03 - Completed raw sample goes to processing
// R04 - Normalize, linearize, scale, low-pass filter
// R05 - Limit violation disarms alarm, sets flag
// R06 - Finished value written to dual-port RAM
// R07 - Processing overlaps the next channel slot
// R08 - Host commands take top priority
// R09 - Mux, gain, converter under internal control only
// R10 - Excitation held for whole slot
// R11 - Excitation type follows sensor type
// R12 - Slot phases: settle, digitize, recover
// R13 - High-speed mode shortens digitize phase
// R14 - At most one reference per sixteen samples
// R15 - Disabled channels leave the scan loop
// R16 - Update rate between 1/((N+1)T) and 1/(NT)
// R17 - Default slot time 22 ms
// R18 - Command service stretches the slot
// R19 - Reads answer within 100 us / 130 us
// R20 - Host avoids excessive command rate
// R21 - Disarmed alarm and flag stay until cleared
`ifndef SSS_DEFINES_SVH
`define SSS_DEFINES_SVH

`define SSS_NCH 16
`define SSS_CLK_HZ 20000000
// Slot phase times in microseconds
`define SSS_SLOT_US 22000
`define SSS_SETTLE_US 3000
`define SSS_DIG_US 16700
`define SSS_DIG_HS_US 4000
`define SSS_SETTLE_CYC ((`SSS_SETTLE_US * (`SSS_CLK_HZ / 1000000)))
`define SSS_SLOT_CYC ((`SSS_SLOT_US * (`SSS_CLK_HZ / 1000000)))
`define SSS_DIG_CYC ((`SSS_DIG_US * (`SSS_CLK_HZ / 1000000)))
`define SSS_DIG_HS_CYC ((`SSS_DIG_HS_US * (`SSS_CLK_HZ / 1000000)))
`define SSS_REF_PERIOD 5'h10
`define SSS_RESP1_US 100
`define SSS_RESPALL_US 130

// Register byte offsets
`define SSS_REG_CTRL 12'h000
`define SSS_REG_STATUS 12'h004
`define SSS_REG_TYPE 12'h008
`define SSS_REG_ARM 12'h00C
`define SSS_REG_LIMLO 12'h010
`define SSS_REG_LIMHI 12'h014
`define SSS_REG_CMD 12'h018
`define SSS_REG_REFVAL 12'h01C
`define SSS_REG_DATA 12'h100
// Control fields
`define SSS_CTRL_RUN 0
`define SSS_CTRL_HS 1
// Command codes written to the command register
`define SSS_CMD_ONE 2'h1
`define SSS_CMD_ALL 2'h2
// Sensor type codes, 3 bits per channel
`define SSS_TYPE_DIS 3'h0
`define SSS_TYPE_VOLT 3'h1
`define SSS_TYPE_GAGE 3'h2
`define SSS_TYPE_RTD 3'h3
`define SSS_TYPE_RLO 3'h4
`define SSS_TYPE_RHI 3'h5
`define SSS_FILT_SHIFT 2
`define SSS_REFVAL_RST 32'h0000_8000

`endif

// *** sss_pkg.sv ***
// Types for the sensor scan sequencer.
// Assumes sss_defines.svh is on the include path.
`include "sss_defines.svh"
package sss_pkg;
   typedef enum logic [1:0] {
      SSS_PH_IDLE = 2'b00,
      SSS_PH_SETTLE = 2'b01,
      SSS_PH_DIG = 2'b10,
      SSS_PH_RECOVER = 2'b11
   } sss_phase_t;
   typedef enum logic [1:0] {
      SSS_EXC_OFF = 2'b00,
      SSS_EXC_V10 = 2'b01,
      SSS_EXC_I1M2 = 2'b10,
      SSS_EXC_V5R = 2'b11
   } sss_exc_t;
endpackage : sss_pkg

// *** sss_crunch_if.sv ***
// Carrier between the scan sequencer and its result pipeline.
// Assumes one clock domain.
`timescale 1ns/100ps
`default_nettype none
interface sss_crunch_if;
   logic valid;
   logic [3:0] chan;
   logic [15:0] raw;
   logic [2:0] stype;
   logic [31:0] refval;
   logic [15:0] lim_lo;
   logic [15:0] lim_hi;
   logic armed;
   logic out_valid;
   logic [3:0] out_chan;
   logic [31:0] out_data;
   logic violation;
   modport seq (output valid, chan, raw, stype, refval, lim_lo, lim_hi,
      armed, input out_valid, out_chan, out_data, violation);
   modport proc (input valid, chan, raw, stype, refval, lim_lo, lim_hi,
      armed, output out_valid, out_chan, out_data, violation);
endinterface : sss_crunch_if
`default_nettype wire

// *** sss_crunch.sv ***
// Result pipeline: normalize, scale, filter, alarm check for one sample.
// Assumes samples arrive at most one per slot, far below its latency.
`timescale 1ns/100ps
`default_nettype none
`include "sss_defines.svh"
module sss_crunch (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // Sample stream
   sss_crunch_if.proc cif
);
   logic [31:0] filt_q [`SSS_NCH];
   logic [31:0] norm_q;
   logic [31:0] lin_q;
   logic [3:0] chan_q;
   logic [1:0] armed_q;
   logic [15:0] lo_q;
   logic [15:0] hi_q;
   logic [2:0] stage_q;
   logic [31:0] filt_d;

   // Normalize against the reference reading, then linearize/scale
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         norm_q <= 32'h0000_0000;
         lin_q <= 32'h0000_0000;
         chan_q <= 4'h0;
         lo_q <= 16'h0000;
         hi_q <= 16'h0000;
         armed_q <= 2'h0;
      end else begin
         if (cif.valid) begin
            // Ratio to reference with reference nominal at 0x8000
            norm_q <= (32'({16'h0000, cif.raw}) << 15) /
               (|cif.refval ? cif.refval : 32'h0000_0001); // R04
            chan_q <= cif.chan;
            lo_q <= cif.lim_lo;
            hi_q <= cif.lim_hi;
            armed_q <= {cif.armed, 1'b0};
         end
         // One scale for all types, square-law bend on every sample as a simple curve
         if (stage_q[0]) begin
            lin_q <= norm_q + ((norm_q * norm_q) >> 20); // R04
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         stage_q <= 3'h0;
      end else begin
         stage_q <= {stage_q[1:0], cif.valid}; // R07
      end
   end

   // Single-pole low-pass
   assign filt_d = filt_q[chan_q] - (filt_q[chan_q] >> `SSS_FILT_SHIFT)
      + (lin_q >> `SSS_FILT_SHIFT);

   for (genvar g = 0; g < `SSS_NCH; g++) begin : g_filt
      always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
         if (!rst_n_i) begin
            filt_q[g] <= 32'h0000_0000;
         end else if (stage_q[1] && chan_q == 4'(g)) begin
            filt_q[g] <= filt_d; // R04
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cif.out_valid <= 1'b0;
         cif.out_chan <= 4'h0;
         cif.out_data <= 32'h0000_0000;
         cif.violation <= 1'b0;
      end else begin
         cif.out_valid <= stage_q[1]; // R06
         cif.out_chan <= chan_q;
         cif.out_data <= filt_d;
         cif.violation <= stage_q[1] && armed_q[1] &&
            ((filt_d[15:0] < lo_q) || (filt_d[15:0] > hi_q)); // R05
      end
   end
endmodule : sss_crunch
`default_nettype wire

// *** sss_scan_top.sv ***
// Scan sequencer top: AXI4-Lite slave, slot timer, excitation, results RAM.
// Assumes a 20 MHz clock; conversion done strobe is a pin, synchronised.
`timescale 1ns/100ps
`default_nettype none
`include "sss_defines.svh"
module sss_scan_top #(
   parameter int unsigned SETTLE_CYC = `SSS_SETTLE_CYC,
   parameter int unsigned DIG_CYC = `SSS_DIG_CYC,
   parameter int unsigned DIG_HS_CYC = `SSS_DIG_HS_CYC,
   parameter int unsigned SLOT_CYC = `SSS_SLOT_CYC
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // AXI4-Lite write address and data
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Analog front end
   output logic [3:0] sense_mux_o,
   output logic [3:0] exc_mux_o,
   output logic ref_sel_o,
   output logic [1:0] exc_kind_o,
   output logic exc_on_o,
   output logic [1:0] pga_gain_o,
   output logic adc_start_o,
   output logic fe_reset_o,
   input wire logic adc_done_i,
   input wire logic [15:0] adc_data_i
);
   // Host-visible state
   logic run_q, hs_q;
   logic [47:0] type_q;
   logic [15:0] arm_q;
   logic alarm_flag_q;
   logic [15:0] lim_lo_q, lim_hi_q;
   logic [31:0] refval_q;
   logic [31:0] ram_q [`SSS_NCH];
   logic [1:0] cmd_q;
   // Scanner state
   sss_pkg::sss_phase_t ph_q;
   logic [24:0] cnt_q;
   logic [3:0] ch_q;
   logic [4:0] since_ref_q;
   logic is_ref_q;
   logic done_s1_q, done_s2_q, done_s3_q;
   logic [15:0] raw_q;
   logic hold_q;
   // Bus slave
   logic aw_have_q, w_have_q;
   logic [11:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic wr_fire, rd_fire;
   logic [3:0] nxt_ch;
   logic nxt_found;
   logic [24:0] dig_len;
   logic any_active;

   sss_crunch_if cif ();

   function automatic logic [2:0] type_of(input logic [47:0] t,
      input logic [3:0] c);
      type_of = t[3*c +: 3];
   endfunction : type_of

   // Write channel capture, either order
   assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
   assign s_axi_wready = !w_have_q && !s_axi_bvalid;
   assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign rd_fire = s_axi_arvalid && s_axi_arready;

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         awaddr_q <= 12'h000;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awaddr_q <= `SSS_REG_CMD) ? 2'b00 : 2'b10;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Registers; full-word writes only take effect with all strobes
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         run_q <= 1'b0;
         hs_q <= 1'b0;
         type_q <= 48'h0000_0000_0000;
         arm_q <= 16'h0000;
         lim_lo_q <= 16'h0000;
         lim_hi_q <= 16'hFFFF;
      end else begin
         if (wr_fire && wstrb_q == 4'hF) begin
            if (awaddr_q == `SSS_REG_CTRL) begin
               run_q <= wdata_q[`SSS_CTRL_RUN];
               hs_q <= wdata_q[`SSS_CTRL_HS]; // R13
            end else if (awaddr_q == `SSS_REG_TYPE) begin
               type_q[3*wdata_q[19:16] +: 3] <= wdata_q[2:0];
            end else if (awaddr_q == `SSS_REG_ARM) begin
               arm_q <= arm_q | wdata_q[15:0]; // R21
            end else if (awaddr_q == `SSS_REG_LIMLO) begin
               lim_lo_q <= wdata_q[15:0];
            end else if (awaddr_q == `SSS_REG_LIMHI) begin
               lim_hi_q <= wdata_q[15:0];
            end
         end
         if (cif.violation) begin
            arm_q[cif.out_chan] <= 1'b0; // R05
         end
      end
   end

   // Alarm flag: set wins over a write-one clear
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         alarm_flag_q <= 1'b0;
      end else if (cif.violation) begin
         alarm_flag_q <= 1'b1; // R05
      end else if (wr_fire && awaddr_q == `SSS_REG_STATUS && wdata_q[0]) begin
         alarm_flag_q <= 1'b0; // R21
      end
   end

   // Read path; data reads are single-cycle, far inside the answer bound
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'b00;
      end else if (rd_fire) begin
         s_axi_rvalid <= 1'b1; // R08 R19
         s_axi_rresp <= 2'b00;
         if (s_axi_araddr == `SSS_REG_CTRL) begin
            s_axi_rdata <= {30'h0, hs_q, run_q};
         end else if (s_axi_araddr == `SSS_REG_STATUS) begin
            s_axi_rdata <= {22'h0, ph_q, ch_q, 3'h0, alarm_flag_q};
         end else if (s_axi_araddr == `SSS_REG_ARM) begin
            s_axi_rdata <= {16'h0, arm_q};
         end else if (s_axi_araddr == `SSS_REG_LIMLO) begin
            s_axi_rdata <= {16'h0, lim_lo_q};
         end else if (s_axi_araddr == `SSS_REG_LIMHI) begin
            s_axi_rdata <= {16'h0, lim_hi_q};
         end else if (s_axi_araddr == `SSS_REG_REFVAL) begin
            s_axi_rdata <= refval_q;
         end else if (s_axi_araddr[11:6] == 6'h04) begin
            s_axi_rdata <= ram_q[s_axi_araddr[5:2]]; // R06
         end else begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b10;
         end
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Command register: any command write, and any bus read, holds scanning for one cycle
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cmd_q <= 2'h0;
         hold_q <= 1'b0;
      end else begin
         hold_q <= (wr_fire && awaddr_q == `SSS_REG_CMD) || rd_fire; // R18
         if (wr_fire && awaddr_q == `SSS_REG_CMD) begin
            cmd_q <= wdata_q[1:0];
         end
      end
   end

   // Done pin synchroniser and edge detect
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         done_s1_q <= 1'b0;
         done_s2_q <= 1'b0;
         done_s3_q <= 1'b0;
      end else begin
         done_s1_q <= adc_done_i;
         done_s2_q <= done_s1_q;
         done_s3_q <= done_s2_q;
      end
   end

   // Next active channel after the current one
   always_comb begin
      nxt_ch = ch_q;
      nxt_found = 1'b0;
      for (int i = 1; i <= `SSS_NCH; i++) begin
         if (!nxt_found &&
            type_of(type_q, 4'(ch_q + 4'(i))) != `SSS_TYPE_DIS) begin
            nxt_ch = 4'(ch_q + 4'(i)); // R15
            nxt_found = 1'b1;
         end
      end
   end
   assign any_active = nxt_found;
   assign dig_len = hs_q ? 25'(DIG_HS_CYC) : 25'(DIG_CYC); // R13

   // Slot sequencer; command service freezes the timer so the slot stretches
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ph_q <= sss_pkg::SSS_PH_IDLE;
         cnt_q <= 25'h000_0000;
         ch_q <= 4'h0;
         since_ref_q <= 5'h00;
         is_ref_q <= 1'b0;
         raw_q <= 16'h0000;
      end else if (!hold_q) begin // R08 R18
         cnt_q <= cnt_q + 25'h000_0001;
         case (ph_q)
            sss_pkg::SSS_PH_IDLE: begin
               cnt_q <= 25'h000_0000;
               if (run_q && any_active) begin
                  if (since_ref_q >= `SSS_REF_PERIOD) begin
                     is_ref_q <= 1'b1; // R14 R16
                     since_ref_q <= 5'h00;
                  end else begin
                     is_ref_q <= 1'b0;
                     ch_q <= nxt_ch; // R01
                     since_ref_q <= since_ref_q + 5'h01;
                  end
                  ph_q <= sss_pkg::SSS_PH_SETTLE;
               end
            end
            sss_pkg::SSS_PH_SETTLE: begin
               if (cnt_q == 25'(SETTLE_CYC - 1)) begin
                  ph_q <= sss_pkg::SSS_PH_DIG; // R02 R12
               end
            end
            sss_pkg::SSS_PH_DIG: begin
               if (done_s2_q && !done_s3_q) begin
                  raw_q <= adc_data_i; // R03
               end
               if (cnt_q >= 25'(SETTLE_CYC) + dig_len - 25'h000_0001) begin
                  ph_q <= sss_pkg::SSS_PH_RECOVER; // R12
               end
            end
            sss_pkg::SSS_PH_RECOVER: begin
               if (cnt_q == 25'(SLOT_CYC - 1)) begin
                  ph_q <= sss_pkg::SSS_PH_IDLE; // R17
               end
            end
            default: ph_q <= sss_pkg::SSS_PH_IDLE;
         endcase
      end
   end

   // Front-end drive: internal only, no host path
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sense_mux_o <= 4'h0;
         exc_mux_o <= 4'h0;
         ref_sel_o <= 1'b0;
         exc_kind_o <= sss_pkg::SSS_EXC_OFF;
         exc_on_o <= 1'b0;
         pga_gain_o <= 2'h0;
         adc_start_o <= 1'b0;
         fe_reset_o <= 1'b0;
      end else begin
         sense_mux_o <= ch_q; // R01 R09
         exc_mux_o <= ch_q;
         ref_sel_o <= is_ref_q;
         pga_gain_o <= type_of(type_q, ch_q) == `SSS_TYPE_GAGE ? 2'h3 : 2'h0;
         case (type_of(type_q, ch_q)) // R11
            `SSS_TYPE_GAGE: exc_kind_o <= sss_pkg::SSS_EXC_V10;
            `SSS_TYPE_RTD, `SSS_TYPE_RLO: exc_kind_o <= sss_pkg::SSS_EXC_I1M2;
            `SSS_TYPE_RHI: exc_kind_o <= sss_pkg::SSS_EXC_V5R;
            default: exc_kind_o <= sss_pkg::SSS_EXC_OFF;
         endcase
         // Passive sensors only, held across the whole slot
         exc_on_o <= (ph_q != sss_pkg::SSS_PH_IDLE) && !is_ref_q &&
            type_of(type_q, ch_q) >= `SSS_TYPE_GAGE &&
            type_of(type_q, ch_q) <= `SSS_TYPE_RHI; // R10
         adc_start_o <= (ph_q == sss_pkg::SSS_PH_SETTLE) && !hold_q &&
            cnt_q == 25'(SETTLE_CYC - 1); // R02
         fe_reset_o <= ph_q == sss_pkg::SSS_PH_RECOVER; // R12
      end
   end

   // Reference result updates normalizer; sensor result goes to pipeline
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         refval_q <= `SSS_REFVAL_RST;
      end else if (!hold_q && ph_q == sss_pkg::SSS_PH_RECOVER &&
         cnt_q == 25'(SLOT_CYC - 1) && is_ref_q && raw_q != 16'h0000) begin
         refval_q <= {16'h0000, raw_q}; // R14
      end
   end

   assign cif.valid = !hold_q && ph_q == sss_pkg::SSS_PH_RECOVER &&
      cnt_q == 25'(SLOT_CYC - 1) && !is_ref_q; // R03 R07
   assign cif.chan = ch_q;
   assign cif.raw = raw_q;
   assign cif.stype = type_of(type_q, ch_q);
   assign cif.refval = refval_q;
   assign cif.lim_lo = lim_lo_q;
   assign cif.lim_hi = lim_hi_q;
   assign cif.armed = arm_q[ch_q];

   sss_crunch u_crunch (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .cif(cif.proc)
   );

   for (genvar g = 0; g < `SSS_NCH; g++) begin : g_ram
      always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
         if (!rst_n_i) begin
            ram_q[g] <= 32'h0000_0000;
         end else if (cif.out_valid && cif.out_chan == 4'(g)) begin
            ram_q[g] <= cif.out_data; // R06
         end
      end
   end
endmodule : sss_scan_top
`default_nettype wire

// *** sss_scan_top_assertions.sv ***
// Checker for the scan sequencer top: front-end sequencing and bus answers.
// Assumes a single clock domain and the top's ports only.
`timescale 1ns/100ps
`default_nettype none
module sss_scan_top_assertions (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // Bus
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   // Front end
   input wire logic [3:0] sense_mux_o,
   input wire logic [3:0] exc_mux_o,
   input wire logic ref_sel_o,
   input wire logic [1:0] exc_kind_o,
   input wire logic exc_on_o,
   input wire logic adc_start_o,
   input wire logic fe_reset_o
);
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rst_n_i);
   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_excite;
      $rose(exc_on_o);
   endsequence
   AST_START_PULSE: assert property (adc_start_o |=> !adc_start_o)
      else $error("conversion start longer than one cycle");
   AST_SETTLE_FIRST: assert property (s_excite |-> !adc_start_o [*8])
      else $error("conversion started before settling");
   AST_MUX_PAIR: assert property (exc_on_o |-> exc_mux_o == sense_mux_o)
      else $error("sense and excitation routed apart");
   AST_EXC_KIND: assert property (exc_on_o |-> exc_kind_o != 2'h0)
      else $error("excitation on with no source kind");
   AST_KIND_HELD: assert property (exc_on_o && $past(exc_on_o)
      && $stable(sense_mux_o) |-> $stable(exc_kind_o))
      else $error("excitation kind changed within slot");
   AST_EXC_TO_END: assert property ($fell(exc_on_o) |->
      ($past(fe_reset_o) || fe_reset_o))
      else $error("excitation dropped before slot end");
   AST_REF_QUIET: assert property (ref_sel_o |-> !exc_on_o)
      else $error("excitation during reference slot");
   AST_RECOVER: assert property (fe_reset_o |-> !adc_start_o)
      else $error("conversion started during recover");
   AST_BRESP: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
      else $error("write response late");
   AST_RRESP: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read response late");
   AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response withdrawn");
endmodule : sss_scan_top_assertions
bind sss_scan_top sss_scan_top_assertions i_sss_scan_top_assertions (
   .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
   .sense_mux_o(sense_mux_o), .exc_mux_o(exc_mux_o), .ref_sel_o(ref_sel_o),
   .exc_kind_o(exc_kind_o), .exc_on_o(exc_on_o), .adc_start_o(adc_start_o),
   .fe_reset_o(fe_reset_o));
`default_nettype wire

// *** sss_adc_model.sv ***
// Converter model: answers a start pulse with data, then a done level.
// Data is valid well before done and holds until done drops, so the synchroniser latches it cleanly.
`timescale 1ns/100ps
`default_nettype none
module sss_adc_model #(
   parameter int LAT = 16
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // Converter pins
   input wire logic adc_start_i,
   output logic adc_done_o,
   output logic [15:0] adc_data_o
);
   int cnt_q;
   logic [15:0] smp_q;
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_q <= 0;
         smp_q <= 16'h1000;
         adc_done_o <= 1'b0;
         adc_data_o <= 16'h5a5a;
      end else begin
         if (adc_start_i) cnt_q <= LAT;
         else if (cnt_q > 0) cnt_q <= cnt_q - 1;
         adc_done_o <= (cnt_q > 1 && cnt_q <= LAT / 2);
         // Outside the hold window the lines toggle every cycle, so no value stays stable
         if (cnt_q > 1 && cnt_q <= LAT - 4) adc_data_o <= smp_q;
         else adc_data_o <= ~adc_data_o;
         if (cnt_q == 1) smp_q <= smp_q + 16'h0111;
      end
   end
endmodule : sss_adc_model
`default_nettype wire

// *** test_sss_scan_top.sv ***
// Bench for the scan sequencer: bus tasks, scan monitor, alarm path.
// Assumes shortened slot parameters and the converter model.
`timescale 1ns/100ps
`default_nettype none
`include "sss_defines.svh"
module test_sss_scan_top;
   logic sys_clk_i = 0, rst_n_i = 0;
   logic [11:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid, done;
   logic [1:0] bresp, rresp, kind, resp;
   logic [3:0] smux;
   logic [15:0] adata;
   logic ref_sel, exc_on, start, ref_q = 0, fe_rst, fe_q = 0;
   int num_errors = 0, samples_checked = 0, bad = 0, nref = 0, nconv = 0;
   int dcnt = 0, dlen = 0;
   logic [1:0] kind_seen [16];
   sss_scan_top #(.SETTLE_CYC(20), .DIG_CYC(40), .DIG_HS_CYC(10),
      .SLOT_CYC(100)) i_sss_scan_top (.sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sense_mux_o(smux),
      .exc_mux_o(), .ref_sel_o(ref_sel), .exc_kind_o(kind), .exc_on_o(exc_on),
      .pga_gain_o(), .adc_start_o(start), .fe_reset_o(fe_rst),
      .adc_done_i(done), .adc_data_i(adata));
   sss_adc_model i_sss_adc_model (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
      .adc_start_i(start), .adc_done_o(done), .adc_data_o(adata));
   initial forever #25 sys_clk_i = ~sys_clk_i;
   always @(posedge sys_clk_i) begin
      ref_q <= ref_sel;
      fe_q <= fe_rst;
      dcnt = start ? 0 : dcnt + 1;
      if (fe_rst && !fe_q) dlen = dcnt;
      if (ref_sel && !ref_q) nref++;
      if (start && !ref_sel) nconv++;
      if (exc_on) begin
         if (!(smux inside {4'h3, 4'h5, 4'h9})) bad++;
         kind_seen[smux] <= kind;
      end
   end
   task automatic close_out;
      $display("checked %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : close_out
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR at %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic give_up;
      num_errors++;
      close_out();
   endtask : give_up
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic ta, tw;
      int n;
      @(posedge sys_clk_i);
      awaddr <= a; awvalid <= 1; wdata <= d; wvalid <= 1; bready <= 1;
      for (n = 0; n < 50; n++) begin
         @(negedge sys_clk_i);
         ta = awvalid & awready;
         tw = wvalid & wready;
         @(posedge sys_clk_i);
         if (ta) awvalid <= 0;
         if (tw) wvalid <= 0;
         if (bvalid && !awvalid && !wvalid) break;
      end
      if (n == 50) give_up();
      resp = bresp;
      bready <= 0;
   endtask : wr
   task automatic rd(input logic [11:0] a, output logic [31:0] d);
      int n;
      @(posedge sys_clk_i);
      araddr <= a; arvalid <= 1; rready <= 1;
      for (n = 0; n < 50; n++) begin
         @(negedge sys_clk_i);
         if (arvalid & arready) begin
            @(posedge sys_clk_i);
            arvalid <= 0;
         end else if (rvalid) begin
            @(posedge sys_clk_i);
            break;
         end else @(posedge sys_clk_i);
      end
      if (n == 50) give_up();
      d = rdata;
      resp = rresp;
      rready <= 0;
   endtask : rd
   task automatic test_resets;
      logic [31:0] v;
      rd(`SSS_REG_CTRL, v); chk(v, 32'h0000_0000);
      rd(`SSS_REG_STATUS, v); chk(v, 32'h0000_0000);
      rd(`SSS_REG_LIMHI, v); chk(v, 32'h0000_ffff);
      rd(12'h080, v); chk(v, 32'h0000_0000); chk(resp, 2'h2);
      wr(12'h020, 32'h0000_0001); chk(resp, 2'h2);
   endtask : test_resets
   task automatic test_scan;
      logic [31:0] v;
      wr(`SSS_REG_TYPE, 32'h0003_0002);
      wr(`SSS_REG_TYPE, 32'h0005_0003);
      wr(`SSS_REG_TYPE, 32'h0009_0005);
      wr(`SSS_REG_ARM, 32'h0000_0008);
      wr(`SSS_REG_LIMHI, 32'h0000_0000);
      wr(`SSS_REG_CTRL, 32'h0000_0001);
      repeat (4000) @(posedge sys_clk_i);
      chk(bad, 0);
      chk(dlen, 41);
      chk(kind_seen[3], 2'h1);
      chk(kind_seen[5], 2'h2);
      chk(kind_seen[9], 2'h3);
      chk(nref > 0 && nref <= nconv / 16 + 1, 1);
      rd(`SSS_REG_DATA + 12'h00c, v); chk(v != 0, 1);
      rd(`SSS_REG_STATUS, v); chk(v[0], 1'b1);
      rd(`SSS_REG_ARM, v); chk(v[3], 1'b0);
      repeat (300) @(posedge sys_clk_i);
      rd(`SSS_REG_STATUS, v); chk(v[0], 1'b1);
      rd(`SSS_REG_ARM, v); chk(v[3], 1'b0);
      wr(`SSS_REG_STATUS, 32'h0000_0001);
      rd(`SSS_REG_STATUS, v); chk(v[0], 1'b0);
   endtask : test_scan
   task automatic test_speed;
      wr(`SSS_REG_CTRL, 32'h0000_0003);
      repeat (300) @(posedge sys_clk_i);
      chk(dlen, 11);
   endtask : test_speed
   initial begin
      repeat (16) @(posedge sys_clk_i);
      rst_n_i <= 1;
      test_resets();
      test_scan();
      test_speed();
      close_out();
   end
endmodule : test_sss_scan_top
`default_nettype wire
